// file: core/rpmc_top.sv
// Reset and low-power mode controller with Avalon-MM register access
`timescale 1ns/1ps
`default_nettype none
module rpmc_top #(
    parameter int MCD_CYCLES = rpmc_pkg::MCD_TIMEOUT_CYC
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic IRQ_PENDING,
    input wire logic VMON_LOW,
    input wire logic RST_PIN_I,
    output logic RST_PIN_O,
    output logic RST_PIN_OE,
    output logic RST_PIN_PULLUP,
    output logic CPU_RST,
    output logic CPU_HALT,
    output logic PERIPH_RST,
    output logic HFOSC_EN,
    output logic [1:0] SYSCLK_SEL,
    output logic [15:0] BOOT_ADDR,
    output logic [7:0] PORT_LATCH_INIT,
    output logic PORT_OPEN_DRAIN,
    output logic PORT_WEAK_PU,
    output logic VMON_EN,
    output logic FLASH_GO,
    output logic LOW_POWER_OK
);
    rpmc_pkg::rpmc_mode_e state;
    rpmc_pkg::rpmc_mode_e next_state;
    logic [4:0] hold;
    logic [4:0] next_hold;
    logic [1:0] pwr;
    logic [1:0] next_pwr;
    logic [7:0] cause;
    logic [7:0] next_cause;
    logic vmon_en;
    logic next_vmon_en;
    logic vmon_src;
    logic next_vmon_src;
    logic mcd_en;
    logic next_mcd_en;
    logic wdt_en;
    logic next_wdt_en;
    logic bypass;
    logic next_bypass;
    logic program_store_write_enable;
    logic next_program_store_write_enable;
    logic flash_go;
    logic next_flash_go;
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic we;
    logic [31:0] wd;
    logic flash_req;
    logic flash_err;
    logic wdt_kick;
    logic [7:0] ev;
    logic div_tick;

    rpmc_tmo_if wdt_t ();
    rpmc_tmo_if mcd_t ();

    ////////////////////////////////////////////////////////////////////////
    // Watchdog clock: system clock divided by 12
    rpmc_div #(
        .DIV(rpmc_pkg::WDT_DIV)
    ) u_div (
        .clk(MCLK),
        .rst(SYS_RST),
        .tick(div_tick)
    );

    // Watchdog keeps counting through idle and stop, held in reset and while disabled
    assign wdt_t.run = wdt_en && (state != rpmc_pkg::MODE_RESET);
    assign wdt_t.clr = wdt_kick;
    assign wdt_t.tick = div_tick;
    assign wdt_t.limit = rpmc_pkg::WDT_TICKS;

    rpmc_tmo u_wdt (
        .clk(MCLK),
        .rst(SYS_RST),
        .t(wdt_t.cnt)
    );

    // Detector timer runs only while stopped; leaving stop rearms it
    assign mcd_t.run = mcd_en && (state == rpmc_pkg::MODE_STOP);
    assign mcd_t.clr = 1'b0;
    assign mcd_t.tick = 1'b1;
    assign mcd_t.limit = 16'(MCD_CYCLES);

    rpmc_tmo u_mcd (
        .clk(MCLK),
        .rst(SYS_RST),
        .t(mcd_t.cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: a write takes effect only on the edge where the wait ends
    assign we = AVS_WRITE && ack;
    assign wd = AVS_WRITEDATA;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
    assign AVS_READDATA = rdata;

    // Flash request and its guard on the supply monitor
    assign flash_req = we && (AVS_ADDRESS == rpmc_pkg::OFS_FLASH)
        && wd[rpmc_pkg::FLASH_GO_BIT] && program_store_write_enable;
    assign flash_err = flash_req && !(vmon_en && vmon_src);
    assign wdt_kick = we && (AVS_ADDRESS == rpmc_pkg::OFS_WDT) && wd[rpmc_pkg::WDT_KICK_BIT];

    // Internal reset events; the pin is ignored while we pull it low ourselves
    always_comb begin
        ev = 8'h00;
        ev[rpmc_pkg::CAUSE_PIN_BIT] = !RST_PIN_I && !RST_PIN_OE;
        ev[rpmc_pkg::CAUSE_MCD_BIT] = mcd_t.expire;
        ev[rpmc_pkg::CAUSE_WDT_BIT] = wdt_t.expire;
        ev[rpmc_pkg::CAUSE_SW_BIT] = we && (AVS_ADDRESS == rpmc_pkg::OFS_CAUSE)
            && wd[rpmc_pkg::CAUSE_SW_BIT];
        ev[rpmc_pkg::CAUSE_VMON_BIT] = VMON_LOW && vmon_en && vmon_src;
        ev[rpmc_pkg::CAUSE_FLERR_BIT] = flash_err;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer and register file, next values
    always_comb begin
        next_state = state;
        next_hold = hold;
        next_pwr = pwr;
        next_cause = cause;
        next_vmon_en = vmon_en;
        next_vmon_src = vmon_src;
        next_mcd_en = mcd_en;
        next_wdt_en = wdt_en;
        next_bypass = bypass;
        next_program_store_write_enable = program_store_write_enable;
        next_flash_go = 1'b0;

        // Register writes
        if (we) begin
            case (AVS_ADDRESS)
                rpmc_pkg::OFS_PWR: begin
                    next_pwr = wd[1:0];
                end
                rpmc_pkg::OFS_CAUSE: begin
                    // Whole-value writes expected; bit 1 keeps the monitor armed
                    next_vmon_src = wd[rpmc_pkg::SRC_VMON_BIT];
                    next_mcd_en = wd[rpmc_pkg::SRC_MCD_BIT];
                end
                rpmc_pkg::OFS_VMON: begin
                    next_vmon_en = wd[rpmc_pkg::VMON_EN_BIT];
                end
                rpmc_pkg::OFS_FSCALE: begin
                    next_bypass = wd[rpmc_pkg::FSCALE_BYPASS_BIT];
                end
                rpmc_pkg::OFS_FLASH: begin
                    next_program_store_write_enable = wd[rpmc_pkg::FLASH_PROGRAM_STORE_WRITE_ENABLE_BIT];
                    next_flash_go = flash_req && !flash_err;
                end
                rpmc_pkg::OFS_WDT: begin
                    next_wdt_en = wd[rpmc_pkg::WDT_EN_BIT];
                end
                default: begin
                    next_pwr = pwr;
                end
            endcase
        end

        // Mode transitions
        case (state)
            rpmc_pkg::MODE_RUN: begin
                // Enter a low-power mode only once the setting write is done
                if (we && (AVS_ADDRESS == rpmc_pkg::OFS_PWR)) begin
                    if (wd[rpmc_pkg::PWR_STOP_BIT]) begin
                        next_state = rpmc_pkg::MODE_STOP;
                    end else if (wd[rpmc_pkg::PWR_IDLE_BIT]) begin
                        next_state = rpmc_pkg::MODE_IDLE;
                    end
                end
            end
            rpmc_pkg::MODE_IDLE: begin
                // Wake on an enabled interrupt; CPU resumes after the setting write
                if (IRQ_PENDING) begin
                    next_state = rpmc_pkg::MODE_RUN;
                    next_pwr[rpmc_pkg::PWR_IDLE_BIT] = 1'b0;
                end
            end
            rpmc_pkg::MODE_STOP: begin
                // Interrupts are not looked at here
                next_state = rpmc_pkg::MODE_STOP;
            end
            rpmc_pkg::MODE_RESET: begin
                if (hold == rpmc_pkg::HOLD_LAST) begin
                    next_state = rpmc_pkg::MODE_RUN;
                    next_hold = 5'h00;
                end else begin
                    next_hold = hold + 5'h01;
                end
            end
            default: begin
                next_state = rpmc_pkg::MODE_RESET;
            end
        endcase

        // Any reset event restarts the reset sequence and loads defaults, keeping the monitor enable and source
        if (|ev) begin
            next_state = rpmc_pkg::MODE_RESET;
            next_hold = 5'h00;
            next_cause = ev;
            next_pwr = 2'b00;
            next_bypass = 1'b0;
            next_program_store_write_enable = 1'b0;
            next_mcd_en = 1'b0;
            next_wdt_en = 1'b1;
            next_flash_go = 1'b0;
        end
    end

    // Bus answer: one wait cycle, read data registered for the release edge
    always_comb begin
        next_ack = (AVS_READ || AVS_WRITE) && !ack;
        next_rdata = rdata;
        if (AVS_READ && !ack) begin
            case (AVS_ADDRESS)
                rpmc_pkg::OFS_PWR: next_rdata = {30'h0, pwr};
                rpmc_pkg::OFS_CAUSE: next_rdata = {24'h0, cause};
                rpmc_pkg::OFS_VMON: next_rdata = {24'h0, vmon_en, vmon_src, 6'h00};
                rpmc_pkg::OFS_FSCALE: next_rdata = {25'h0, bypass, 6'h00};
                rpmc_pkg::OFS_FLASH: next_rdata = {31'h0, program_store_write_enable};
                rpmc_pkg::OFS_WDT: next_rdata = {31'h0, wdt_en};
                rpmc_pkg::OFS_STATUS: next_rdata = {29'h0, mcd_en, state};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; RAM lives outside and is never written here
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= rpmc_pkg::MODE_RESET;
            hold <= 5'h00;
            pwr <= 2'b00;
            cause <= rpmc_pkg::CAUSE_POR_RST;
            vmon_en <= 1'b1;
            vmon_src <= 1'b1;
            mcd_en <= 1'b0;
            wdt_en <= 1'b1;
            bypass <= 1'b0;
            program_store_write_enable <= 1'b0;
            flash_go <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            hold <= next_hold;
            pwr <= next_pwr;
            cause <= next_cause;
            vmon_en <= next_vmon_en;
            vmon_src <= next_vmon_src;
            mcd_en <= next_mcd_en;
            wdt_en <= next_wdt_en;
            bypass <= next_bypass;
            program_store_write_enable <= next_program_store_write_enable;
            flash_go <= next_flash_go;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core and peripheral control, all decoded from registered state
    assign CPU_RST = (state == rpmc_pkg::MODE_RESET);
    assign PERIPH_RST = (state == rpmc_pkg::MODE_RESET);
    // Halt freezes the core clock, so its registers and memory hold
    assign CPU_HALT = (state == rpmc_pkg::MODE_IDLE) || (state == rpmc_pkg::MODE_STOP);
    // Only the precision oscillator stops; the others are not ours
    assign HFOSC_EN = (state != rpmc_pkg::MODE_STOP);
    assign SYSCLK_SEL = rpmc_pkg::SYSCLK_INTOSC;
    assign BOOT_ADDR = rpmc_pkg::BOOT_ADDR_RST;
    assign PORT_LATCH_INIT = rpmc_pkg::PORT_LATCH_RST;
    assign PORT_OPEN_DRAIN = (state == rpmc_pkg::MODE_RESET);
    assign PORT_WEAK_PU = 1'b1;
    assign VMON_EN = vmon_en;
    assign FLASH_GO = flash_go;
    // Low power is reached only with the one-shot enabled
    assign LOW_POWER_OK = CPU_HALT && !bypass;

    // Reset pin: pulled low for monitor resets, floating during power-on
    assign RST_PIN_O = 1'b0;
    assign RST_PIN_OE = CPU_RST && cause[rpmc_pkg::CAUSE_VMON_BIT];
    assign RST_PIN_PULLUP = !(CPU_RST && cause[rpmc_pkg::CAUSE_POR_BIT]);
endmodule
`default_nettype wire

// file: shared/rpmc_pkg.sv
// Constants, offsets and types of the reset and power mode controller
package rpmc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_HOLD_NS = 100;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MCD_TIMEOUT_NS = 100000;
    localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int WDT_DIV = 12;
    localparam logic [15:0] WDT_TICKS = 16'h00FF;
    localparam int TMO_W = 16;

    // Register byte offsets
    localparam logic [4:0] OFS_PWR = 5'h00;
    localparam logic [4:0] OFS_CAUSE = 5'h04;
    localparam logic [4:0] OFS_VMON = 5'h08;
    localparam logic [4:0] OFS_FSCALE = 5'h0C;
    localparam logic [4:0] OFS_FLASH = 5'h10;
    localparam logic [4:0] OFS_WDT = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // Field positions
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int CAUSE_PIN_BIT = 0;
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_MCD_BIT = 2;
    localparam int CAUSE_WDT_BIT = 3;
    localparam int CAUSE_SW_BIT = 4;
    localparam int CAUSE_VMON_BIT = 5;
    localparam int CAUSE_FLERR_BIT = 6;
    localparam int SRC_VMON_BIT = 1;
    localparam int SRC_MCD_BIT = 2;
    localparam int VMON_EN_BIT = 7;
    localparam int VMON_SRC_BIT = 6;
    localparam int FSCALE_BYPASS_BIT = 6;
    localparam int FLASH_PROGRAM_STORE_WRITE_ENABLE_BIT = 0;
    localparam int FLASH_GO_BIT = 1;
    localparam int WDT_EN_BIT = 0;
    localparam int WDT_KICK_BIT = 1;

    // Values after reset
    localparam logic [7:0] CAUSE_POR_RST = 8'h02;
    localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
    localparam logic [15:0] BOOT_ADDR_RST = 16'h0000;
    localparam logic [1:0] SYSCLK_INTOSC = 2'h0;
    localparam logic [4:0] HOLD_LAST = 5'(RST_HOLD_CYC - 1);

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STOP = 2'b10,
        MODE_RESET = 2'b11
    } rpmc_mode_e;

endpackage

// file: shared/rpmc_tmo_if.sv
// Control and result signals of one timeout counter
`timescale 1ns/1ps
`default_nettype none
interface rpmc_tmo_if;
    logic run;
    logic clr;
    logic tick;
    logic [15:0] limit;
    logic expire;
    modport ctl (output run, output clr, output tick, output limit, input expire);
    modport cnt (input run, input clr, input tick, input limit, output expire);
endinterface
`default_nettype wire

// file: core/rpmc_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module rpmc_div #(
    parameter int DIV = 12
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_tick;

    // Wrap at DIV-1 and pulse on the wrap
    always_comb begin
        next_tick = (cnt == 4'(DIV - 1));
        next_cnt = next_tick ? 4'h0 : cnt + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// file: core/rpmc_tmo.sv
// Timeout counter: pulses expire after limit ticks of run
`timescale 1ns/1ps
`default_nettype none
module rpmc_tmo (
    input wire logic clk,
    input wire logic rst,
    rpmc_tmo_if.cnt t
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_expire;
    logic expire_q;

    // Clear wins over counting, so a kick in the last tick saves the day
    always_comb begin
        next_cnt = cnt;
        next_expire = 1'b0;
        if (t.clr || !t.run) begin
            next_cnt = 16'h0000;
        end else if (t.tick) begin
            if (cnt == t.limit - 16'h0001) begin
                next_cnt = 16'h0000;
                next_expire = 1'b1;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            expire_q <= 1'b0;
        end else begin
            cnt <= next_cnt;
            expire_q <= next_expire;
        end
    end

    assign t.expire = expire_q;
endmodule
`default_nettype wire

// file: tb/rpmc_assertions.sv
// Port checker of the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpmc_assertions (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic IRQ_PENDING,
    input wire logic RST_PIN_O,
    input wire logic RST_PIN_OE,
    input wire logic RST_PIN_PULLUP,
    input wire logic CPU_RST,
    input wire logic CPU_HALT,
    input wire logic PERIPH_RST,
    input wire logic HFOSC_EN,
    input wire logic [1:0] SYSCLK_SEL,
    input wire logic [15:0] BOOT_ADDR,
    input wire logic [7:0] PORT_LATCH_INIT,
    input wire logic PORT_OPEN_DRAIN,
    input wire logic PORT_WEAK_PU,
    input wire logic VMON_EN,
    input wire logic FLASH_GO
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////////////
    // Write taken at this edge, outside reset
    wire logic wr_ok;
    assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && !CPU_RST;
    ////////////////////////////////////////////////////////////////////////////////
    // Mode entry and exit
    AST_IDLE_IN: assert property (wr_ok && AVS_ADDRESS == rpmc_pkg::OFS_PWR
        && AVS_WRITEDATA[1:0] == 2'h1 |=> CPU_HALT && HFOSC_EN) else $error("idle not entered");
    AST_STOP_IN: assert property (wr_ok && AVS_ADDRESS == rpmc_pkg::OFS_PWR
        && AVS_WRITEDATA[1:0] == 2'h2 |=> CPU_HALT && !HFOSC_EN) else $error("stop not entered");
    AST_STOP_HOLD: assert property (!HFOSC_EN |=> !HFOSC_EN || CPU_RST)
        else $error("stop left without reset");
    AST_IDLE_WAKE: assert property (CPU_HALT && HFOSC_EN && IRQ_PENDING && !CPU_RST
        |=> !CPU_HALT) else $error("idle kept after interrupt");
    // Reset state outputs; the full hold must stand before release
    AST_RST_STATE: assert property (CPU_RST |-> PERIPH_RST && PORT_OPEN_DRAIN && !CPU_HALT)
        else $error("reset state outputs wrong");
    AST_RST_HOLD: assert property ($fell(CPU_RST) |-> $past(CPU_RST, rpmc_pkg::RST_HOLD_CYC))
        else $error("reset hold too short");
    AST_PORT: assert property (PORT_LATCH_INIT == rpmc_pkg::PORT_LATCH_RST && PORT_WEAK_PU)
        else $error("port defaults wrong");
    AST_EXIT: assert property (SYSCLK_SEL == rpmc_pkg::SYSCLK_INTOSC
        && BOOT_ADDR == rpmc_pkg::BOOT_ADDR_RST) else $error("exit defaults wrong");
    AST_PIN: assert property (RST_PIN_OE |-> CPU_RST && !RST_PIN_O)
        else $error("reset pin driven outside reset");
    AST_PULL: assert property (!RST_PIN_PULLUP |-> CPU_RST && !RST_PIN_OE && VMON_EN)
        else $error("pull-up off outside power-on reset");
    // Flash operation only from an accepted go write with monitor on
    AST_FLASH: assert property (FLASH_GO |-> $past(wr_ok && AVS_ADDRESS == rpmc_pkg::OFS_FLASH
        && AVS_WRITEDATA[1]) && $past(VMON_EN)) else $error("flash go unguarded");
    AST_FLERR: assert property (wr_ok && AVS_ADDRESS == rpmc_pkg::OFS_FLASH
        && AVS_WRITEDATA[1:0] == 2'h3 && !VMON_EN |=> CPU_RST) else $error("no flash error reset");
    COV_WAKE: cover property (CPU_HALT && HFOSC_EN && IRQ_PENDING);
    COV_STOP: cover property (!HFOSC_EN ##1 CPU_RST);
    COV_GO: cover property (FLASH_GO);
endmodule
bind rpmc_top rpmc_assertions rpmc_assertions_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ_PENDING(IRQ_PENDING), .RST_PIN_O(RST_PIN_O),
    .RST_PIN_OE(RST_PIN_OE), .RST_PIN_PULLUP(RST_PIN_PULLUP), .CPU_RST(CPU_RST),
    .CPU_HALT(CPU_HALT), .PERIPH_RST(PERIPH_RST), .HFOSC_EN(HFOSC_EN),
    .SYSCLK_SEL(SYSCLK_SEL), .BOOT_ADDR(BOOT_ADDR), .PORT_LATCH_INIT(PORT_LATCH_INIT),
    .PORT_OPEN_DRAIN(PORT_OPEN_DRAIN), .PORT_WEAK_PU(PORT_WEAK_PU), .VMON_EN(VMON_EN),
    .FLASH_GO(FLASH_GO));
`default_nettype wire

// file: tb/rpmc_top_tb_top.sv
// Testbench of the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpmc_top_tb_top;
    localparam int MISSING_CLOCK_DETECTOR = 50;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic IRQ_PENDING = 1'b0;
    logic VMON_LOW = 1'b0;
    logic pin_drv = 1'b1;
    wire logic RST_PIN_I;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, RST_PIN_O, RST_PIN_OE, RST_PIN_PULLUP, CPU_RST, CPU_HALT;
    logic PERIPH_RST, HFOSC_EN, PORT_OPEN_DRAIN, PORT_WEAK_PU, VMON_EN, FLASH_GO, LOW_POWER_OK;
    logic [1:0] SYSCLK_SEL;
    logic [15:0] BOOT_ADDR;
    logic [7:0] PORT_LATCH_INIT;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int go_cnt = 0;
    int n, g;
    logic oe;
    // Pin wire: the block's drive wins over the external pull-up side
    assign RST_PIN_I = RST_PIN_OE ? RST_PIN_O : pin_drv;
    rpmc_top #(.MCD_CYCLES(MISSING_CLOCK_DETECTOR)) rpmc_top_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ_PENDING(IRQ_PENDING), .VMON_LOW(VMON_LOW),
        .RST_PIN_I(RST_PIN_I), .RST_PIN_O(RST_PIN_O), .RST_PIN_OE(RST_PIN_OE),
        .RST_PIN_PULLUP(RST_PIN_PULLUP), .CPU_RST(CPU_RST), .CPU_HALT(CPU_HALT),
        .PERIPH_RST(PERIPH_RST), .HFOSC_EN(HFOSC_EN), .SYSCLK_SEL(SYSCLK_SEL),
        .BOOT_ADDR(BOOT_ADDR), .PORT_LATCH_INIT(PORT_LATCH_INIT),
        .PORT_OPEN_DRAIN(PORT_OPEN_DRAIN), .PORT_WEAK_PU(PORT_WEAK_PU), .VMON_EN(VMON_EN),
        .FLASH_GO(FLASH_GO), .LOW_POWER_OK(LOW_POWER_OK));
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 MCLK = ~MCLK;
    // Flash pulse counter and run ceiling, well above the watchdog wait
    always @(posedge MCLK) begin
        cyc++;
        if (FLASH_GO === 1'b1) go_cnt++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle; an edge passes first so strobes never toggle twice in a step
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_READ <= !w;
        AVS_WRITE <= w;
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // Ride one reset through, drop its stimulus, park the watchdog
    task automatic rst_seq(output logic o);
        while (CPU_RST !== 1'b1) @(posedge MCLK);
        o = RST_PIN_OE;
        VMON_LOW <= 1'b0;
        pin_drv <= 1'b1;
        while (CPU_RST !== 1'b0) @(posedge MCLK);
        wr(rpmc_pkg::OFS_WDT, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        chk({RST_PIN_PULLUP, RST_PIN_OE, CPU_RST, PORT_OPEN_DRAIN}, 4'h3);
        n = 1;
        while (CPU_RST !== 1'b0) begin
            @(posedge MCLK);
            n++;
        end
        chk(n, rpmc_pkg::RST_HOLD_CYC + 1);
        wr(rpmc_pkg::OFS_WDT, 32'h0);
        rd(rpmc_pkg::OFS_CAUSE, 32'h02);
        rd(rpmc_pkg::OFS_VMON, 32'hC0);
        rd(5'h1C, 32'h0);
        rd(rpmc_pkg::OFS_STATUS, 32'h0);
        chk({BOOT_ADDR, SYSCLK_SEL}, 18'h0);
        chk({PORT_LATCH_INIT, PORT_WEAK_PU, VMON_EN}, 10'h3FF);
        g = go_cnt;
        wr(rpmc_pkg::OFS_FLASH, 32'h01);
        wr(rpmc_pkg::OFS_VMON, 32'h80);
        wr(rpmc_pkg::OFS_FLASH, 32'h03);
        repeat (2) @(posedge MCLK);
        chk({go_cnt - g, CPU_RST}, 2);
        // Idle with bypass set: no low power, state kept across wake
        wr(rpmc_pkg::OFS_FSCALE, 32'h40);
        wr(rpmc_pkg::OFS_PWR, 32'h01);
        repeat (2) @(posedge MCLK);
        chk({CPU_HALT, HFOSC_EN, LOW_POWER_OK}, 3'h6);
        IRQ_PENDING <= 1'b1;
        repeat (2) @(posedge MCLK);
        IRQ_PENDING <= 1'b0;
        chk(CPU_HALT, 0);
        rd(rpmc_pkg::OFS_PWR, 32'h0);
        rd(rpmc_pkg::OFS_FSCALE, 32'h40);
        // Watchdog must end a low-power idle
        wr(rpmc_pkg::OFS_FSCALE, 32'h0);
        wr(rpmc_pkg::OFS_WDT, 32'h01);
        wr(rpmc_pkg::OFS_PWR, 32'h01);
        repeat (2) @(posedge MCLK);
        chk(LOW_POWER_OK, 1);
        rst_seq(oe);
        rd(rpmc_pkg::OFS_CAUSE, 32'h08);
        rd(rpmc_pkg::OFS_STATUS, 32'h0);
        // Stop ignores interrupts; detector ends it
        wr(rpmc_pkg::OFS_CAUSE, 32'h06);
        rd(rpmc_pkg::OFS_STATUS, 32'h4);
        wr(rpmc_pkg::OFS_PWR, 32'h02);
        IRQ_PENDING <= 1'b1;
        repeat (5) @(posedge MCLK);
        IRQ_PENDING <= 1'b0;
        chk({CPU_HALT, HFOSC_EN, CPU_RST}, 3'h4);
        n = 0;
        while (CPU_RST !== 1'b1) begin
            @(posedge MCLK);
            n++;
        end
        chk(n >= MISSING_CLOCK_DETECTOR - 5 && n <= MISSING_CLOCK_DETECTOR, 1);
        rst_seq(oe);
        rd(rpmc_pkg::OFS_CAUSE, 32'h04);
        wr(rpmc_pkg::OFS_CAUSE, 32'h02);
        // Monitor off: flash go becomes a flash error reset
        wr(rpmc_pkg::OFS_VMON, 32'h0);
        g = go_cnt;
        wr(rpmc_pkg::OFS_FLASH, 32'h01);
        wr(rpmc_pkg::OFS_FLASH, 32'h03);
        rst_seq(oe);
        chk({go_cnt - g, VMON_EN}, 0);
        rd(rpmc_pkg::OFS_CAUSE, 32'h40);
        // Monitor reset drives the pin low
        wr(rpmc_pkg::OFS_VMON, 32'h80);
        VMON_LOW <= 1'b1;
        rst_seq(oe);
        chk(oe, 1);
        rd(rpmc_pkg::OFS_CAUSE, 32'h20);
        pin_drv <= 1'b0;
        rst_seq(oe);
        rd(rpmc_pkg::OFS_CAUSE, 32'h01);
        wr(rpmc_pkg::OFS_CAUSE, 32'h12);
        rst_seq(oe);
        rd(rpmc_pkg::OFS_CAUSE, 32'h10);
        finish_test();
    end
endmodule
`default_nettype wire
